// >>> hdl/almost_full_store.v
// per-channel store of the latest almost-full indication
`timescale 1ns/1ps
`default_nettype none
`include "rr_sched_map.vh"

module almost_full_store #(
	parameter NUM_CHANNELS = `RRS_MAX_CHANNELS,
	parameter CHAN_W       = `RRS_CHAN_W
) (
	input  wire                    sys_clk,
	input  wire                    rst_n,
	input  wire                    upd_valid,
	input  wire [CHAN_W-1:0]       upd_channel,
	input  wire                    upd_full,
	output wire [NUM_CHANNELS-1:0] full_flags
);

	reg [NUM_CHANNELS-1:0] flags_r;
	reg [NUM_CHANNELS-1:0] flags_nxt;
	integer                i;

	always @* begin
		flags_nxt = flags_r;
		// beats naming a channel at or above the configured count are dropped
		for (i = 0; i < NUM_CHANNELS; i = i + 1) begin
			if (upd_valid && (upd_channel == i[CHAN_W-1:0])) begin
				flags_nxt[i] = upd_full;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= {NUM_CHANNELS{1'b0}};
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign full_flags = flags_r;

endmodule // almost_full_store

`default_nettype wire

// >>> hdl/channel_pointer.v
// wrapping round-robin channel pointer
`timescale 1ns/1ps
`default_nettype none
`include "rr_sched_map.vh"

module channel_pointer #(
	parameter NUM_CHANNELS = `RRS_MAX_CHANNELS,
	parameter PTR_W        = 5
) (
	input  wire             sys_clk,
	input  wire             rst_n,
	input  wire             advance,
	output wire [PTR_W-1:0] ptr
);

	localparam integer     LAST_INT = NUM_CHANNELS - 1;
	localparam [PTR_W-1:0] LAST_CH  = LAST_INT[PTR_W-1:0];

	reg [PTR_W-1:0] ptr_r;
	reg [PTR_W-1:0] ptr_nxt;

	always @* begin
		ptr_nxt = ptr_r;
		if (advance) begin
			if (ptr_r == LAST_CH) begin
				ptr_nxt = {PTR_W{1'b0}};
			end else begin
				ptr_nxt = ptr_r + 1'b1;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_r <= {PTR_W{1'b0}};
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	assign ptr = ptr_r;

endmodule // channel_pointer

`default_nettype wire

// >>> hdl/round_robin_read_scheduler.v
// round-robin read scheduler for a channel-segmented buffer
`timescale 1ns/1ps
`default_nettype none
`include "rr_sched_map.vh"

module round_robin_read_scheduler #(
	parameter NUM_CHANNELS    = `RRS_MAX_CHANNELS,
	parameter USE_ALMOST_FULL = 1,
	parameter WDATA_W         = `RRS_WDATA_W,
	parameter ADDR_W          = clog2(NUM_CHANNELS) + `RRS_ADDR_SHIFT
) (
	input  wire                   sys_clk,
	input  wire                   rst_n,
	output wire [ADDR_W-1:0]      request_address,
	output wire                   request_write,
	output wire [WDATA_W-1:0]     request_writedata,
	input  wire                   request_waitrequest,
	input  wire                   almost_full_valid,
	input  wire [`RRS_CHAN_W-1:0] almost_full_channel,
	input  wire                   almost_full_data
);

	function integer clog2;
		input integer value;
		integer       v;
		begin
			v = value - 1;
			clog2 = 0;
			while (v > 0) begin
				clog2 = clog2 + 1;
				v = v >> 1;
			end
		end
	endfunction

	localparam PTR_W = clog2(NUM_CHANNELS);

	localparam [WDATA_W-1:0] BEATS = `RRS_BEATS_PER_REQ;

	wire [PTR_W-1:0]        ptr;
	wire [NUM_CHANNELS-1:0] full_flags;
	wire                    stall;
	wire                    cur_full;
	wire                    bypass_hit;

	reg [ADDR_W-1:0] addr_r;
	reg [ADDR_W-1:0] addr_nxt;
	reg              write_r;
	reg              write_nxt;

	// a write held by waitrequest must stay on the bus unchanged
	assign stall = request_waitrequest;

	almost_full_store #(
		.NUM_CHANNELS (NUM_CHANNELS),
		.CHAN_W       (`RRS_CHAN_W)
	) u_store (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.upd_valid   (almost_full_valid && (USE_ALMOST_FULL != 0)),
		.upd_channel (almost_full_channel),
		.upd_full    (almost_full_data),
		.full_flags  (full_flags)
	);

	channel_pointer #(
		.NUM_CHANNELS (NUM_CHANNELS),
		.PTR_W        (PTR_W)
	) u_ptr (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.advance (!stall),
		.ptr     (ptr)
	);

	// a beat for the channel being scheduled right now overrides the stored
	// flag, so a fresh almost-full is honoured without a cycle of lag
	assign bypass_hit = almost_full_valid &&
	                    (almost_full_channel == {{(`RRS_CHAN_W-PTR_W){1'b0}}, ptr});
	assign cur_full   = (USE_ALMOST_FULL == 0) ? 1'b0 :
	                    (bypass_hit ? almost_full_data : full_flags[ptr]);

	always @* begin
		addr_nxt  = addr_r;
		write_nxt = write_r;
		if (!stall) begin
			addr_nxt  = {ptr, {`RRS_ADDR_SHIFT{1'b0}}};
			write_nxt = !cur_full;
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r  <= {ADDR_W{1'b0}};
			write_r <= 1'b0;
		end else begin
			addr_r  <= addr_nxt;
			write_r <= write_nxt;
		end
	end

	assign request_address   = addr_r;
	assign request_write     = write_r;
	assign request_writedata = BEATS;

endmodule // round_robin_read_scheduler

`default_nettype wire

// >>> hdl/rr_sched_map.vh
// constants shared by the round-robin read scheduler files
`ifndef RR_SCHED_MAP_VH
`define RR_SCHED_MAP_VH

// channel number carried with each status beat
`define RRS_CHAN_W        5
// most channels that the status channel number can name
`define RRS_MAX_CHANNELS  32
// least channel count supported
`define RRS_MIN_CHANNELS  2
// beats asked for by every request
`define RRS_BEATS_PER_REQ 1
// request address is channel times four
`define RRS_ADDR_SHIFT    2
// default width of the request write data
`define RRS_WDATA_W       32

`endif

// >>> tb/round_robin_read_scheduler_tb.sv
// scheduler self-checking bench
`timescale 1ns/1ps
`default_nettype none
module round_robin_read_scheduler_tb;
	logic sys_clk = 1'h0, rst_n = 1'h1, stall = 1'h0;
	logic request_write, request_waitrequest, almost_full_valid, almost_full_data;
	logic nf_write;
	logic [3:0] full_mask = 4'h0, request_address, a0;
	logic [4:0] almost_full_channel;
	logic [31:0] request_writedata, n;
	int n_mismatch = 0, compares = 0;
	always #5 sys_clk = ~sys_clk;
	round_robin_read_scheduler #(.NUM_CHANNELS(4)) i_round_robin_read_scheduler (.*);
	// second copy with the status input left out sees the same status beats
	round_robin_read_scheduler #(
		.NUM_CHANNELS    (4),
		.USE_ALMOST_FULL (0)
	) i_round_robin_read_scheduler_nf (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.request_address     (),
		.request_write       (nf_write),
		.request_writedata   (),
		.request_waitrequest (request_waitrequest),
		.almost_full_valid   (almost_full_valid),
		.almost_full_channel (almost_full_channel),
		.almost_full_data    (almost_full_data)
	);
	rr_buffer_model i_rr_buffer_model (.*);
	task tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task check(input logic [31:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task t_walk;
		a0 = request_address;
		repeat (8) begin
			tick(1);
			a0 = a0 + 4'h4;
			check(request_address, a0, "addr");
		end
	endtask
	// eight slots are two whole rounds whatever the phase
	task t_full(input logic [3:0] m);
		full_mask = m;
		tick(12);
		n = 0;
		a0 = request_address;
		repeat (8) begin
			tick(1);
			a0 = a0 + 4'h4;
			n = n + request_write;
			check(request_write, !m[a0[3:2]], "skip");
			check(nf_write, 1'h1, "no skip");
		end
		check(n, 8 - 2 * $countones(m), "writes");
	endtask
	task t_stall;
		stall = 1'h1;
		tick(2);
		a0 = request_address + 4'h4;
		tick(4);
		stall = 1'h0;
		tick(2);
		check(request_address, a0, "resume");
	endtask
	// reset lands between edges, so the clear must not wait for a clock
	task t_reset;
		#2 rst_n = 1'h0;
		#1 check({request_write, request_address}, 5'h00, "async clear");
		tick(2);
		rst_n = 1'h1;
		tick(1);
		check({request_write, request_address}, 5'h10, "restart");
	endtask
	initial begin
		#1 rst_n = 1'h0;
		tick(16);
		rst_n = 1'h1;
		tick(1);
		check({request_write, request_address}, 5'h10, "start");
		check(request_writedata, 32'h1, "beats");
		t_walk;
		t_full(4'h9);
		t_full(4'h0);
		t_stall;
		t_reset;
		wrap_up;
	end
	initial begin
		#9000 n_mismatch++;
		wrap_up;
	end
endmodule // round_robin_read_scheduler_tb
`default_nettype wire

// >>> tb/rr_buffer_model.sv
// far-side buffer model: stall and almost-full status
`timescale 1ns/1ps
`default_nettype none
module rr_buffer_model (
	input wire logic sys_clk,
	input wire logic stall,
	input wire logic [3:0] full_mask,
	output wire logic request_waitrequest,
	output wire logic almost_full_valid,
	output wire logic [4:0] almost_full_channel,
	output wire logic almost_full_data
);
	logic [2:0] s_r = 3'h0;
	logic w_r = 1'h0;
	always @(posedge sys_clk) {s_r, w_r} <= {s_r + 3'h1, stall};
	assign request_waitrequest = w_r;
	assign almost_full_valid = !s_r[0];
	// idle cycles show a moving pattern so stale status cannot pass
	assign almost_full_channel = s_r[0] ? {s_r, 2'h3} : {3'h0, ~s_r[2:1]};
	assign almost_full_data = s_r[0] ? s_r[1] : full_mask[~s_r[2:1]];
endmodule // rr_buffer_model
`default_nettype wire

// >>> tb/rr_sched_asserts.sv
// scheduler port checks
`timescale 1ns/1ps
`default_nettype none
module rr_sched_asserts #(parameter N = 4, A = 4, W = 32) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [A-1:0] request_address,
	input wire logic request_write,
	input wire logic [W-1:0] request_writedata,
	input wire logic request_waitrequest
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire [A-1:0] nxt = request_address >> 2 == N - 1 ? '0 : request_address + 3'h4;
	a_data_one: assert property (request_writedata == 1'h1) else $error("data");
	a_addr_word: assert property (request_address[1:0] == 2'h0) else $error("addr");
	a_addr_range: assert property (request_address >> 2 < N) else $error("range");
	a_step_next: assert property ($past(rst_n) && !request_waitrequest
		|=> request_address == $past(nxt)) else $error("step");
	a_stall_hold: assert property (request_waitrequest |=> $stable(request_address))
		else $error("hold");
	a_stall_keep: assert property (request_waitrequest && request_write |=> request_write)
		else $error("keep");
	a_reset_idle: assert property (disable iff (1'h0) !rst_n |-> !request_write)
		else $error("reset");
	a_start_zero: assert property ($rose(rst_n) |=> request_address == 1'h0)
		else $error("start");
	c_skip: cover property (!request_write);
	c_stall: cover property (request_waitrequest && request_write);
	c_wrap: cover property (request_address == 1'h0);
endmodule // rr_sched_asserts
bind round_robin_read_scheduler rr_sched_asserts #(.N(NUM_CHANNELS), .A(ADDR_W), .W(WDATA_W))
	i_rr_sched_asserts (.*);
`default_nettype wire
